// File: kwu_pkg.sv
package kwsr_pkg;

   // Register indices; byte address is four times the index
   localparam logic [11:0] KWSR_IDX_ENABLE  = 12'hF9A;
   localparam logic [11:0] KWSR_IDX_CTRL    = 12'hF9B;
   localparam logic [11:0] KWSR_IDX_STATUS  = 12'hF9C;

   // Enable field of key_wake_enable_reg
   localparam int          KWSR_EN_LSB      = 4;
   localparam int          KWSR_EN_MSB      = 7;
   localparam logic [3:0]  KWSR_EN_RESET    = 4'h0;

   // Control register fields
   localparam int          KWSR_CTRL_LEVEL  = 0;
   localparam int          KWSR_CTRL_STOP   = 1;
   localparam logic        KWSR_LEVEL_RESET = 1'b1;

   // Warm-up time after release
   localparam int          KWSR_WARM_NS     = 1000;
   localparam int          KWSR_CLK_NS      = 100;
   localparam int          KWSR_WARM_CYC    =
      (KWSR_WARM_NS + KWSR_CLK_NS - 1) / KWSR_CLK_NS;

   // Synchroniser idle levels: keys idle high, stop pin idle low
   localparam logic [5:0]  KWSR_SYNC_RESET  = 6'h1E;
   localparam int          KWSR_SYNC_W      = 6;

   typedef enum logic [1:0]
   {
      KWSR_RUN  = 2'b00,
      KWSR_STOP = 2'b01,
      KWSR_WARM = 2'b10
   } kwsr_state_t;

   typedef struct packed
   {
      logic [24:0] reserved;
      logic        stop_level;
      logic [3:0]  key_level;
      logic        wake_level;
      logic        stopped;
   } kwsr_status_t;

endpackage

// File: kwu_top.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
// Operation
// R1 - Stop pin and four keys release stop
// R2 - Each key has its own enable bit
// R3 - Enables at bits 7..4, reset zero
// R4 - Enable register is write-only, reads zero
// R5 - Software sets key port pins as inputs
// R6 - In stop, enabled low key releases
// R7 - Software checks enabled keys high first
// R8 - Edge mode: keys disabled or held high
// R9 - Pending release at entry skips stop
// R10 - Stop pin always active, held low
// R11 - Level mode: levels; edge mode: rising stop
// R12 - Wake request is OR of sources
module kwsr_top
#(
   parameter int WARM_CYC = kwsr_pkg::KWSR_WARM_CYC
)
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        port2_bit0,
   input  wire logic        key_wake_input_a,
   input  wire logic        key_wake_input_b,
   input  wire logic        key_wake_input_c,
   input  wire logic        key_wake_input_d,
   output logic             stop_mode,
   output logic             warm_up,
   output logic             wake_request
);

   logic [3:0]               key_wake_enable_reg;
   logic                     level_mode;
   logic [5:0]               sync1;
   logic [5:0]               sync2;
   logic [5:0]               sync3;
   logic [5:0]               filt;
   logic [5:0]               raw;
   logic [3:0]               keys_raw;
   logic                     wake_raw;
   logic                     stop_f;
   logic [3:0]               key_f;
   logic                     wake_f;
   logic                     stop_prev;
   logic                     stop_rise;
   logic                     key_hit;
   logic                     level_rel;
   logic                     stop_req;
   logic                     acc;
   logic                     setup;
   logic [15:0]              warm_cnt;
   kwsr_pkg::kwsr_state_t    state;
   kwsr_pkg::kwsr_state_t    next_state;
   kwsr_pkg::kwsr_status_t   status;

   function automatic logic kwsr_hit(input logic [15:0] a,
                                     input logic [11:0] idx);
      kwsr_hit = (a == {2'b00, idx, 2'b00});
   endfunction

   assign keys_raw = {key_wake_input_d, key_wake_input_c,
                      key_wake_input_b, key_wake_input_a};
   // Combinational OR needs no clock; only its sampling does
   assign wake_raw = port2_bit0 |
                     (|(key_wake_enable_reg & ~keys_raw)); // [R12]
   assign raw      = {wake_raw, keys_raw, port2_bit0};

   // Three-stage synchronisers; third stage only confirms the second
   genvar gi;
   generate
      for (gi = 0; gi < kwsr_pkg::KWSR_SYNC_W; gi++)
      begin : g_sync
         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
            begin
               sync1[gi] <= kwsr_pkg::KWSR_SYNC_RESET[gi];
               sync2[gi] <= kwsr_pkg::KWSR_SYNC_RESET[gi];
               sync3[gi] <= kwsr_pkg::KWSR_SYNC_RESET[gi];
               filt[gi]  <= kwsr_pkg::KWSR_SYNC_RESET[gi];
            end
            else
            begin
               sync1[gi] <= raw[gi];
               sync2[gi] <= sync1[gi];
               sync3[gi] <= sync2[gi];
               if (sync2[gi] == sync3[gi])
               begin
                  filt[gi] <= sync3[gi];
               end
            end
         end
      end
   endgenerate

   assign stop_f    = filt[0];
   assign key_f     = filt[4:1];
   assign wake_f    = filt[5];
   assign stop_rise = stop_f & ~stop_prev;
   assign key_hit   = |(key_wake_enable_reg & ~key_f); // [R1] [R2]
   assign level_rel = stop_f | key_hit;

   assign setup = psel & ~penable;
   assign acc   = psel & penable & pready;
   assign stop_req = acc & pwrite & kwsr_hit(paddr, kwsr_pkg::KWSR_IDX_CTRL)
                     & pwdata[kwsr_pkg::KWSR_CTRL_STOP];

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stop_prev <= 1'b0;
      end
      else
      begin
         stop_prev <= stop_f;
      end
   end

   // Register writes take effect at the access edge only
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         key_wake_enable_reg <= kwsr_pkg::KWSR_EN_RESET; // [R3]
         level_mode          <= kwsr_pkg::KWSR_LEVEL_RESET;
      end
      else if (acc && pwrite)
      begin
         if (kwsr_hit(paddr, kwsr_pkg::KWSR_IDX_ENABLE))
         begin
            key_wake_enable_reg <= pwdata[kwsr_pkg::KWSR_EN_MSB:
                                          kwsr_pkg::KWSR_EN_LSB]; // [R2] [R3]
         end
         if (kwsr_hit(paddr, kwsr_pkg::KWSR_IDX_CTRL))
         begin
            level_mode <= pwdata[kwsr_pkg::KWSR_CTRL_LEVEL];
         end
      end
   end

   always_comb
   begin
      status            = '0;
      status.stopped    = stop_mode;
      status.wake_level = wake_f;
      status.key_level  = key_f;
      status.stop_level = stop_f;
   end

   // No wait state: pready rises with penable, in the first access cycle
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= setup;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         if (setup)
         begin
            if (kwsr_hit(paddr, kwsr_pkg::KWSR_IDX_ENABLE))
            begin
               // Write-only; the enables are never read back
               prdata <= 32'h0000_0000; // [R4]
            end
            else if (kwsr_hit(paddr, kwsr_pkg::KWSR_IDX_CTRL))
            begin
               prdata <= {31'h0000_0000, level_mode};
            end
            else if (kwsr_hit(paddr, kwsr_pkg::KWSR_IDX_STATUS))
            begin
               prdata <= pwrite ? 32'h0000_0000 : status;
               pslverr <= pwrite;
            end
            else
            begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   always_comb
   begin
      next_state = state;
      case (state)
         kwsr_pkg::KWSR_RUN:
         begin
            if (stop_req)
            begin
               // Pending source means warm-up at once
               next_state = level_rel ? kwsr_pkg::KWSR_WARM
                                      : kwsr_pkg::KWSR_STOP; // [R9]
            end
         end
         kwsr_pkg::KWSR_STOP:
         begin
            if (level_mode ? level_rel : stop_rise) // [R6] [R11]
            begin
               next_state = kwsr_pkg::KWSR_WARM;
            end
         end
         kwsr_pkg::KWSR_WARM:
         begin
            if (warm_cnt == 16'(WARM_CYC - 1))
            begin
               next_state = kwsr_pkg::KWSR_RUN;
            end
         end
         default:
         begin
            next_state = kwsr_pkg::KWSR_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state     <= kwsr_pkg::KWSR_RUN;
         stop_mode <= 1'b0;
         warm_up   <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         stop_mode <= (next_state == kwsr_pkg::KWSR_STOP);
         warm_up   <= (next_state == kwsr_pkg::KWSR_WARM);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         warm_cnt <= 16'h0000;
      end
      else if (state == kwsr_pkg::KWSR_WARM)
      begin
         warm_cnt <= warm_cnt + 16'h0001;
      end
      else
      begin
         warm_cnt <= 16'h0000;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wake_request <= 1'b0;
      end
      else
      begin
         wake_request <= wake_f; // [R12]
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_stopped_level;
      state == kwsr_pkg::KWSR_STOP && level_mode;
   endsequence

   sequence s_entry_pending;
      state == kwsr_pkg::KWSR_RUN && stop_req && level_rel;
   endsequence

   AST_ENTRY_SKIP: assert property (s_entry_pending |=> // [R9]
      state == kwsr_pkg::KWSR_WARM && warm_up ##1 warm_up)
      else $error("stop entered despite pending release");

   AST_KEY_RELEASE: assert property (s_stopped_level and key_hit // [R6]
      |=> state == kwsr_pkg::KWSR_WARM)
      else $error("enabled low key did not release stop");

   AST_DISABLED_KEY: assert property (s_stopped_level and !stop_f // [R1]
      and !key_hit |=> state == kwsr_pkg::KWSR_STOP)
      else $error("stop left with no release source");

   AST_EDGE_KEYS: assert property (state == kwsr_pkg::KWSR_STOP // [R11]
      && !level_mode && !stop_rise |=> stop_mode)
      else $error("edge mode left stop without rising edge");

   AST_EDGE_RISE: assert property (state == kwsr_pkg::KWSR_STOP // [R11]
      && !level_mode && stop_rise |=> warm_up)
      else $error("edge mode missed rising stop edge");

   AST_READ_ZERO: assert property (setup && !pwrite && // [R4]
      kwsr_hit(paddr, kwsr_pkg::KWSR_IDX_ENABLE) |=> prdata == 32'h0000_0000)
      else $error("enable register read back non-zero");

   AST_WRITE_EN: assert property (acc && pwrite && // [R2]
      kwsr_hit(paddr, kwsr_pkg::KWSR_IDX_ENABLE) |=>
      key_wake_enable_reg == $past(pwdata[7:4]))
      else $error("enable write not stored at bits 7..4");

   AST_WAKE_OR: assert property (s_stopped_level and wake_f // [R12]
      and $stable(key_wake_enable_reg) |=> !stop_mode)
      else $error("wake request did not release level stop");

endmodule

// File: kwu_key_model.sv
`timescale 1ns/1ps
module kwsr_key_model
(
   input  wire logic [3:0] press,
   input  wire logic       pin_req,
   output logic            key_wake_input_a,
   output logic            key_wake_input_b,
   output logic            key_wake_input_c,
   output logic            key_wake_input_d,
   output logic            port2_bit0
);
   // Pull-ups: a released key reads high
   assign {key_wake_input_d, key_wake_input_c, key_wake_input_b,
      key_wake_input_a} = ~press;
   assign port2_bit0 = pin_req;
endmodule

// File: tb_key_wakeup_stop_release.sv
`timescale 1ns/1ps
module tb_key_wakeup_stop_release;
   localparam int          WARM = 2;
   localparam logic [15:0] A_EN = {2'b00, kwsr_pkg::KWSR_IDX_ENABLE, 2'b00};
   localparam logic [15:0] A_CT = {2'b00, kwsr_pkg::KWSR_IDX_CTRL, 2'b00};
   localparam logic [15:0] A_ST = {2'b00, kwsr_pkg::KWSR_IDX_STATUS, 2'b00};
   logic        clk_sys = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic        pin_req = 1'b0;
   logic [15:0] paddr   = 16'h0000;
   logic [31:0] pwdata  = 32'h00000000;
   logic [3:0]  press   = 4'h0;
   logic [31:0] seed    = 32'h52CE2534;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, stop_mode, warm_up, wake_request, err;
   logic        ka, kb, kc, kd, p20;
   int          fail_count = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          i, j;

   kwsr_top #(.WARM_CYC(WARM)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .port2_bit0(p20), .key_wake_input_a(ka),
      .key_wake_input_b(kb), .key_wake_input_c(kc),
      .key_wake_input_d(kd), .stop_mode(stop_mode), .warm_up(warm_up),
      .wake_request(wake_request));
   kwsr_key_model i_keys (.press(press), .pin_req(pin_req),
      .key_wake_input_a(ka), .key_wake_input_b(kb),
      .key_wake_input_c(kc), .key_wake_input_d(kd), .port2_bit0(p20));

   always #50 clk_sys = ~clk_sys;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   // Idle status: not stopped, pin low, no wake
   function automatic logic [31:0] exp_status(input logic [3:0] p);
      return {25'h0, 1'b0, ~p, 2'b00};
   endfunction

   task print_verdict;
   begin
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
   begin
      samples_checked++;
      if (g !== e)
      begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   end
   endtask

   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
   begin
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      // Slave answers in the first access cycle
      chk("pready_wait", 32'h1, n);
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask

   task expect_st(input logic [1:0] e, input int lim);
      int n;
   begin
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while ({stop_mode, warm_up} !== e && n < lim);
      chk("state", {30'h0, e}, {30'h0, stop_mode, warm_up});
   end
   endtask

   task release_chk(input int lim);
      int n;
   begin
      expect_st(2'b01, lim);
      n = 0;
      while (warm_up === 1'b1 && n < 50)
      begin
         @(posedge clk_sys);
         n++;
      end
      chk("warm_len", WARM, n);
   end
   endtask

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fail_count++;
         print_verdict;
      end
   end

   initial
   begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      apb(1'b0, A_EN, 32'h0);
      chk("en_reset", 32'h0, rd);
      apb(1'b0, A_CT, 32'h0);
      chk("ctrl_reset", 32'h1, rd);
      apb(1'b1, A_EN, 32'hF0);
      apb(1'b0, A_EN, 32'h0);
      chk("en_wo", 32'h0, rd);
      apb(1'b0, 16'h0100, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
      apb(1'b1, A_EN, 32'h0);
      seed = xs(seed);
      press <= seed[3:0];
      repeat (6) @(posedge clk_sys);
      apb(1'b0, A_ST, 32'h0);
      chk("status", exp_status(seed[3:0]), rd);
      apb(1'b1, A_ST, 32'h0);
      chk("st_write", 32'h1, {31'h0, err});
      for (i = 0; i < 4; i++)
      begin
         seed = xs(seed);
         j = (i + 1 + seed[1:0] % 3) % 4;
         press <= 4'h0;
         repeat (6) @(posedge clk_sys);
         apb(1'b1, A_EN, {24'h0, 4'(1 << i), seed[7:4]});
         apb(1'b1, A_CT, 32'h3);
         expect_st(2'b10, 1);
         press <= 4'(1 << j);
         repeat (8) @(posedge clk_sys);
         chk("off_key", 32'h2, {30'h0, stop_mode, warm_up});
         chk("wake_off", 32'h0, {31'h0, wake_request});
         press <= 4'(1 << i);
         release_chk(10);
         chk("wake", 32'h1, {31'h0, wake_request});
      end
      apb(1'b1, A_CT, 32'h3);
      release_chk(1);
      press <= 4'h0;
      apb(1'b1, A_EN, 32'h0);
      repeat (6) @(posedge clk_sys);
      apb(1'b1, A_CT, 32'h3);
      expect_st(2'b10, 1);
      pin_req <= 1'b1;
      release_chk(10);
      pin_req <= 1'b0;
      apb(1'b1, A_EN, 32'h20);
      repeat (6) @(posedge clk_sys);
      apb(1'b1, A_CT, 32'h2);
      expect_st(2'b10, 1);
      // Held-high rule broken on purpose: keys must be ignored
      press <= 4'h2;
      repeat (8) @(posedge clk_sys);
      chk("edge_key", 32'h2, {30'h0, stop_mode, warm_up});
      press <= 4'h0;
      repeat (4) @(posedge clk_sys);
      pin_req <= 1'b1;
      release_chk(10);
      pin_req <= 1'b0;
      apb(1'b0, A_CT, 32'h0);
      chk("ctrl_edge", 32'h0, rd);
      print_verdict;
   end
endmodule
